/* File: accel_cfg_pkg.sv */
// Function
// [R1] Feature port 0x5E read/write, passes accesses through
// [R2] Error bit 1 on overrun, processing halts
// [R3] Error bit 2 on fatal error, processing halts
// [R4] Bit 1 of 0x6A permits nonvolatile programming
// [R5] Interface bit 0 selects three-wire SPI
// [R6] Interface bit 4 enables auxiliary magnetometer master
// [R7] Self-test bit 0 enables excitation, resets zero
// [R8] Self-test bit 2 selects excitation polarity
// [R9] Self-test bit 3 selects deflection amplitude
// [R10] Bit 0 of 0x70 chooses SPI over I2C
// [R11] Bit 1 of 0x70 selects watchdog period
// [R12] Bit 2 of 0x70 enables I2C watchdog
// [R13] Bit 3 of 0x70 enables axis offsets
// [R14] X offset byte at 0x71, resets zero
// [R15] Y offset byte at 0x72, resets zero
// [R16] Bits of 0x70 backed by nonvolatile storage
// [R17] Program command copies backed registers to storage
// [R18] Primary interface starts in I2C mode
// [R19] Reserved bits read zero, ignore writes
// [R20] Watchdog expiry releases line, idles I2C slave
package accel_cfg_pkg;
   // ==========================================================
   // Register offsets and command codes
   localparam logic [7:0] FEAT_ADDR    = 8'h5E;
   localparam logic [7:0] ERR_ADDR     = 8'h5F;
   localparam logic [7:0] NVP_ADDR     = 8'h6A;
   localparam logic [7:0] IFC_ADDR     = 8'h6B;
   localparam logic [7:0] STC_ADDR     = 8'h6D;
   localparam logic [7:0] NVC_ADDR     = 8'h70;
   localparam logic [7:0] XOFF_ADDR    = 8'h71;
   localparam logic [7:0] YOFF_ADDR    = 8'h72;
   localparam logic [7:0] CMD_ADDR     = 8'h7E;
   localparam logic [7:0] CMD_NVM_PROG = 8'hA0;
   // ==========================================================
   // Field positions, writable masks, reset values
   localparam int         ERR_OVR_BIT  = 1;
   localparam int         ERR_FAT_BIT  = 2;
   localparam int         NVP_EN_BIT   = 1;
   localparam int         IFC_3W_BIT   = 0;
   localparam int         IFC_AUX_BIT  = 4;
   localparam int         ST_EN_BIT    = 0;
   localparam int         ST_SIGN_BIT  = 2;
   localparam int         ST_AMP_BIT   = 3;
   localparam int         NVC_SPI_BIT  = 0;
   localparam int         NVC_WSEL_BIT = 1;
   localparam int         NVC_WEN_BIT  = 2;
   localparam int         NVC_OFF_BIT  = 3;
   localparam logic [7:0] NVP_MASK     = 8'h02;
   localparam logic [7:0] IFC_MASK     = 8'h11;
   localparam logic [7:0] STC_MASK     = 8'h0D;
   localparam logic [7:0] NVC_MASK     = 8'h0F;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam int         IMAGE_W      = 20;
   // ==========================================================
   // Watchdog timing
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         WDT_SHORT_NS  = 1250000;
   localparam int         WDT_LONG_NS   = 40000000;
   localparam int         WDT_SHORT_CYC = WDT_SHORT_NS / CLK_PERIOD_NS;
   localparam int         WDT_LONG_CYC  = WDT_LONG_NS / CLK_PERIOD_NS;
   localparam int         WDT_W         = 20;
endpackage

/* File: accel_config_register_bank.sv */
`timescale 1ns/100ps
module accel_config_register_bank #(
   parameter int WDT_SHORT = accel_cfg_pkg::WDT_SHORT_CYC,
   parameter int WDT_LONG  = accel_cfg_pkg::WDT_LONG_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Register access from the primary serial front end
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   // Feature configuration storage
   input  wire logic [7:0]  feat_rdata_i,
   output logic             feat_wr_o,
   output logic             feat_rd_o,
   output logic      [7:0]  feat_wdata_o,
   // Processing engine
   input  wire logic        proc_overrun_i,
   input  wire logic        proc_fatal_i,
   output logic             proc_halt_o,
   // Nonvolatile controller
   input  wire logic        nvm_load_i,
   input  wire logic [19:0] nvm_load_data_i,
   input  wire logic        nvm_busy_i,
   output logic             nvm_prog_en_o,
   output logic             nvm_prog_o,
   output logic      [19:0] nvm_image_o,
   // Interface configuration
   input  wire logic        i2c_mode_i,
   input  wire logic        sda_low_i,
   output logic             three_wire_select_o,
   output logic             aux_mag_o,
   output logic             spi_en_o,
   output logic             wdt_expire_o,
   // Self-test and offsets
   output logic             selftest_en_o,
   output logic             selftest_pos_o,
   output logic             selftest_high_o,
   output logic             offset_en_o,
   output logic      [7:0]  x_offset_o,
   output logic      [7:0]  y_offset_o
);

   // ==========================================================
   // Types and state
   typedef enum logic [1:0] {
      NV_IDLE = 2'b01,
      NV_PROG = 2'b10
   } nv_state_t;

   nv_state_t              nv_state_q;
   nv_state_t              nv_state_d;
   logic       [7:0]       feat_q;
   logic       [7:0]       feat_d;
   logic       [7:0]       err_q;
   logic       [7:0]       err_d;
   logic       [7:0]       nvp_q;
   logic       [7:0]       nvp_d;
   logic       [7:0]       ifc_q;
   logic       [7:0]       ifc_d;
   logic       [7:0]       stc_q;
   logic       [7:0]       stc_d;
   logic       [7:0]       nvc_q;
   logic       [7:0]       nvc_d;
   logic       [7:0]       xoff_q;
   logic       [7:0]       xoff_d;
   logic       [7:0]       yoff_q;
   logic       [7:0]       yoff_d;
   logic       [7:0]       rdata_q;
   logic       [7:0]       rdata_d;
   logic                   feat_wr_q;
   logic                   feat_wr_d;
   logic                   feat_rd_q;
   logic                   feat_rd_d;
   logic                   prog_q;
   logic                   prog_d;
   logic       [19:0]      image_q;
   logic       [19:0]      image_d;
   logic       [19:0]      wdt_cnt_q;
   logic       [19:0]      wdt_cnt_d;
   logic                   wdt_exp_q;
   logic                   wdt_exp_d;
   logic                   halt_q;
   logic                   halt_d;
   logic                   prog_cmd;
   logic       [19:0]      wdt_limit;

   // ==========================================================
   // Register file
   always_comb begin
      feat_d    = feat_q;
      err_d     = err_q;
      nvp_d     = nvp_q;
      ifc_d     = ifc_q;
      stc_d     = stc_q;
      nvc_d     = nvc_q;
      xoff_d    = xoff_q;
      yoff_d    = yoff_q;
      feat_wr_d = 1'b0;
      feat_rd_d = 1'b0;
      // Error flags are sticky until reset
      if (proc_overrun_i) begin
         err_d[accel_cfg_pkg::ERR_OVR_BIT] = 1'b1; // R2
      end
      if (proc_fatal_i) begin
         err_d[accel_cfg_pkg::ERR_FAT_BIT] = 1'b1; // R3
      end
      halt_d    = err_d[accel_cfg_pkg::ERR_OVR_BIT] | err_d[accel_cfg_pkg::ERR_FAT_BIT]; // R2 R3
      // Restore of the backed bits from storage
      if (nvm_load_i) begin
         nvc_d  = {4'h0, nvm_load_data_i[3:0]}; // R16
         xoff_d = nvm_load_data_i[11:4];
         yoff_d = nvm_load_data_i[19:12];
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            accel_cfg_pkg::FEAT_ADDR: begin
               feat_d    = reg_wdata_i; // R1
               feat_wr_d = 1'b1;
            end
            accel_cfg_pkg::NVP_ADDR: begin
               nvp_d = reg_wdata_i & accel_cfg_pkg::NVP_MASK; // R4 R19
            end
            accel_cfg_pkg::IFC_ADDR: begin
               ifc_d = reg_wdata_i & accel_cfg_pkg::IFC_MASK; // R5 R6 R19
            end
            accel_cfg_pkg::STC_ADDR: begin
               stc_d = reg_wdata_i & accel_cfg_pkg::STC_MASK; // R7 R8 R9 R19
            end
            accel_cfg_pkg::NVC_ADDR: begin
               nvc_d = reg_wdata_i & accel_cfg_pkg::NVC_MASK; // R10 R11 R12 R13
            end
            accel_cfg_pkg::XOFF_ADDR: begin
               xoff_d = reg_wdata_i; // R14
            end
            accel_cfg_pkg::YOFF_ADDR: begin
               yoff_d = reg_wdata_i; // R15
            end
            default: begin
            end
         endcase
      end
      if (reg_rd_i && reg_addr_i == accel_cfg_pkg::FEAT_ADDR) begin
         feat_rd_d = 1'b1; // R1
      end
   end

   // ==========================================================
   // Read path, one cycle after the read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         case (reg_addr_i)
            accel_cfg_pkg::FEAT_ADDR: rdata_d = feat_rdata_i; // R1
            accel_cfg_pkg::ERR_ADDR:  rdata_d = err_q;
            accel_cfg_pkg::NVP_ADDR:  rdata_d = nvp_q;
            accel_cfg_pkg::IFC_ADDR:  rdata_d = ifc_q;
            accel_cfg_pkg::STC_ADDR:  rdata_d = stc_q;
            accel_cfg_pkg::NVC_ADDR:  rdata_d = nvc_q;
            accel_cfg_pkg::XOFF_ADDR: rdata_d = xoff_q;
            accel_cfg_pkg::YOFF_ADDR: rdata_d = yoff_q;
            default:                  rdata_d = 8'h00; // R19
         endcase
      end
   end

   // ==========================================================
   // Nonvolatile program sequencer
   assign prog_cmd = reg_wr_i && reg_addr_i == accel_cfg_pkg::CMD_ADDR
                     && reg_wdata_i == accel_cfg_pkg::CMD_NVM_PROG;

   always_comb begin
      nv_state_d = nv_state_q;
      prog_d     = 1'b0;
      image_d    = image_q;
      case (nv_state_q)
         NV_IDLE: begin
            if (prog_cmd && nvp_q[accel_cfg_pkg::NVP_EN_BIT]) begin
               prog_d     = 1'b1; // R17 R4
               image_d    = {yoff_q, xoff_q, nvc_q[3:0]}; // R16
               nv_state_d = NV_PROG;
            end
         end
         NV_PROG: begin
            if (!prog_q && !nvm_busy_i) begin
               nv_state_d = NV_IDLE;
            end
         end
         default: nv_state_d = NV_IDLE;
      endcase
   end

   // ==========================================================
   // I2C data line watchdog
   assign wdt_limit = nvc_q[accel_cfg_pkg::NVC_WSEL_BIT] ? WDT_LONG[19:0]
                                                         : WDT_SHORT[19:0]; // R11

   always_comb begin
      wdt_cnt_d = 20'h00000;
      wdt_exp_d = 1'b0;
      if (nvc_q[accel_cfg_pkg::NVC_WEN_BIT] && i2c_mode_i && sda_low_i) begin // R12
         if (wdt_cnt_q >= wdt_limit - 20'h00001) begin
            wdt_exp_d = 1'b1; // R20
         end else begin
            wdt_cnt_d = wdt_cnt_q + 20'h00001;
         end
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         nv_state_q <= NV_IDLE;
         feat_q     <= accel_cfg_pkg::REG_RESET;
         err_q      <= accel_cfg_pkg::REG_RESET;
         nvp_q      <= accel_cfg_pkg::REG_RESET;
         ifc_q      <= accel_cfg_pkg::REG_RESET;
         stc_q      <= accel_cfg_pkg::REG_RESET;
         nvc_q      <= accel_cfg_pkg::REG_RESET; // R18
         xoff_q     <= accel_cfg_pkg::REG_RESET;
         yoff_q     <= accel_cfg_pkg::REG_RESET;
         rdata_q    <= 8'h00;
         feat_wr_q  <= 1'b0;
         feat_rd_q  <= 1'b0;
         prog_q     <= 1'b0;
         image_q    <= 20'h00000;
         wdt_cnt_q  <= 20'h00000;
         wdt_exp_q  <= 1'b0;
         halt_q     <= 1'b0;
      end else begin
         nv_state_q <= nv_state_d;
         feat_q     <= feat_d;
         err_q      <= err_d;
         nvp_q      <= nvp_d;
         ifc_q      <= ifc_d;
         stc_q      <= stc_d;
         nvc_q      <= nvc_d;
         xoff_q     <= xoff_d;
         yoff_q     <= yoff_d;
         rdata_q    <= rdata_d;
         feat_wr_q  <= feat_wr_d;
         feat_rd_q  <= feat_rd_d;
         prog_q     <= prog_d;
         image_q    <= image_d;
         wdt_cnt_q  <= wdt_cnt_d;
         wdt_exp_q  <= wdt_exp_d;
         halt_q     <= halt_d;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o         = rdata_q;
   assign feat_wr_o           = feat_wr_q;
   assign feat_rd_o           = feat_rd_q;
   assign feat_wdata_o        = feat_q;
   assign proc_halt_o         = halt_q; // R2 R3
   assign nvm_prog_en_o       = nvp_q[accel_cfg_pkg::NVP_EN_BIT]; // R4
   assign nvm_prog_o          = prog_q;
   assign nvm_image_o         = image_q;
   assign three_wire_select_o = ifc_q[accel_cfg_pkg::IFC_3W_BIT]; // R5
   assign aux_mag_o           = ifc_q[accel_cfg_pkg::IFC_AUX_BIT]; // R6
   assign spi_en_o            = nvc_q[accel_cfg_pkg::NVC_SPI_BIT]; // R10
   assign wdt_expire_o        = wdt_exp_q;
   assign selftest_en_o       = stc_q[accel_cfg_pkg::ST_EN_BIT]; // R7
   assign selftest_pos_o      = stc_q[accel_cfg_pkg::ST_SIGN_BIT]; // R8
   assign selftest_high_o     = stc_q[accel_cfg_pkg::ST_AMP_BIT]; // R9
   assign offset_en_o         = nvc_q[accel_cfg_pkg::NVC_OFF_BIT]; // R13
   assign x_offset_o          = xoff_q;
   assign y_offset_o          = yoff_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_prog_cmd;
      prog_cmd && nvm_prog_en_o && nv_state_q == NV_IDLE;
   endsequence
   sequence s_prog_pulse;
      nvm_prog_o && nvm_image_o == {$past(yoff_q), $past(xoff_q), $past(nvc_q[3:0])};
   endsequence

   a_feat_write: assert property ( // R1
      reg_wr_i && reg_addr_i == accel_cfg_pkg::FEAT_ADDR && !nvm_load_i
      |=> feat_wr_o && feat_wdata_o == $past(reg_wdata_i))
      else $error("feature write not passed through");
   a_overrun_halt: assert property ( // R2
      proc_overrun_i |=> err_q[1] && proc_halt_o [*3])
      else $error("overrun flag or halt missing");
   a_fatal_sticky: assert property ( // R3
      err_q[2] |=> err_q[2] && proc_halt_o)
      else $error("fatal flag cleared");
   a_prog_gated: assert property ( // R4
      !nvm_prog_en_o && nv_state_q == NV_IDLE |=> !nvm_prog_o)
      else $error("program without enable");
   a_prog_copy: assert property ( // R17
      s_prog_cmd |=> s_prog_pulse)
      else $error("program image wrong");
   a_ifc_reserved: assert property ( // R19
      (ifc_q & ~accel_cfg_pkg::IFC_MASK) == 8'h00
      && (stc_q & ~accel_cfg_pkg::STC_MASK) == 8'h00
      && (nvc_q & ~accel_cfg_pkg::NVC_MASK) == 8'h00)
      else $error("reserved bit set");
   a_err_read: assert property ( // R2
      reg_rd_i && reg_addr_i == accel_cfg_pkg::ERR_ADDR |=> reg_rdata_o == $past(err_q))
      else $error("error register readback wrong");
   a_xoff_write: assert property ( // R14
      reg_wr_i && reg_addr_i == accel_cfg_pkg::XOFF_ADDR && !nvm_load_i
      |=> x_offset_o == $past(reg_wdata_i) ##1 x_offset_o == $past(reg_wdata_i, 2)
          || $past(reg_wr_i) || $past(nvm_load_i))
      else $error("x offset write lost");
   a_wdt_idle: assert property ( // R12
      !nvc_q[2] || !i2c_mode_i || !sda_low_i |=> wdt_cnt_q == 20'h00000 && !wdt_expire_o)
      else $error("watchdog ran while disabled");
   a_wdt_fire: assert property ( // R20
      wdt_cnt_q == wdt_limit - 20'h00001 && nvc_q[2] && i2c_mode_i && sda_low_i
      |=> wdt_expire_o ##1 !wdt_expire_o || wdt_cnt_q != 20'h00000)
      else $error("watchdog expiry wrong");
   a_selftest_map: assert property ( // R7
      reg_wr_i && reg_addr_i == accel_cfg_pkg::STC_ADDR
      |=> selftest_en_o == $past(reg_wdata_i[0]) && selftest_pos_o == $past(reg_wdata_i[2])
          && selftest_high_o == $past(reg_wdata_i[3]))
      else $error("self-test fields wrong");

endmodule

/* File: host_model.sv */
`timescale 1ns/100ps
module host_model (
   input  wire logic       mclk_i,
   output logic            reg_wr_i,
   output logic            reg_rd_i,
   output logic [7:0]      reg_addr_i,
   output logic [7:0]      reg_wdata_i,
   input  wire logic [7:0] reg_rdata_o
);
   initial begin
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
   end
   // ==========================================================
   // Byte write: strobe held for one taking edge, then lines scrambled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i) #1;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge mclk_i) #1;
      reg_wr_i = 1'b0;
      reg_addr_i = ~a;
      reg_wdata_i = ~d;
   endtask
   // ==========================================================
   // Byte read: data taken 1 ns after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i) #1;
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge mclk_i) #1;
      d = reg_rdata_o;
      reg_rd_i = 1'b0;
      reg_addr_i = ~a;
   endtask
endmodule

/* File: accel_config_register_bank_tb.sv */
`timescale 1ns/100ps
module accel_config_register_bank_tb;
   logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, feat_wr_o, feat_rd_o;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, feat_rdata_i, feat_wdata_o;
   logic        proc_overrun_i, proc_fatal_i, proc_halt_o, nvm_load_i, nvm_busy_i;
   logic [19:0] nvm_load_data_i, nvm_image_o;
   logic        nvm_prog_en_o, nvm_prog_o, i2c_mode_i, sda_low_i, three_wire_select_o;
   logic        aux_mag_o, spi_en_o, wdt_expire_o, selftest_en_o, selftest_pos_o;
   logic        selftest_high_o, offset_en_o;
   logic [7:0]  x_offset_o, y_offset_o, v, rv;
   logic [7:0]  sh [6];
   logic [7:0]  al [7];
   int          mismatches, check_count, n;

   accel_config_register_bank #(.WDT_SHORT(8), .WDT_LONG(20)) accel_config_register_bank_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .feat_rdata_i(feat_rdata_i), .feat_wr_o(feat_wr_o), .feat_rd_o(feat_rd_o),
      .feat_wdata_o(feat_wdata_o), .proc_overrun_i(proc_overrun_i),
      .proc_fatal_i(proc_fatal_i), .proc_halt_o(proc_halt_o), .nvm_load_i(nvm_load_i),
      .nvm_load_data_i(nvm_load_data_i), .nvm_busy_i(nvm_busy_i),
      .nvm_prog_en_o(nvm_prog_en_o), .nvm_prog_o(nvm_prog_o), .nvm_image_o(nvm_image_o),
      .i2c_mode_i(i2c_mode_i), .sda_low_i(sda_low_i),
      .three_wire_select_o(three_wire_select_o), .aux_mag_o(aux_mag_o),
      .spi_en_o(spi_en_o), .wdt_expire_o(wdt_expire_o), .selftest_en_o(selftest_en_o),
      .selftest_pos_o(selftest_pos_o), .selftest_high_o(selftest_high_o),
      .offset_en_o(offset_en_o), .x_offset_o(x_offset_o), .y_offset_o(y_offset_o));

   host_model host_model_inst (.mclk_i(mclk_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o));

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         accel_cfg_pkg::NVP_ADDR: return accel_cfg_pkg::NVP_MASK;
         accel_cfg_pkg::IFC_ADDR: return accel_cfg_pkg::IFC_MASK;
         accel_cfg_pkg::STC_ADDR: return accel_cfg_pkg::STC_MASK;
         accel_cfg_pkg::NVC_ADDR: return accel_cfg_pkg::NVC_MASK;
         accel_cfg_pkg::XOFF_ADDR, accel_cfg_pkg::YOFF_ADDR: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] cfg_view(input logic [7:0] p, i, s, c);
      return {p[1], i[0], i[4], s[0], s[2], s[3], c[0], c[3]};
   endfunction
   task automatic do_reset;
      @(posedge mclk_i) #1;
      rst_n_i = 1'b0;
      repeat (20) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
   endtask
   task automatic step;
      @(posedge mclk_i) #1;
   endtask
   task automatic wdt_run(input logic sel, input int lim);
      host_model_inst.wr(accel_cfg_pkg::NVC_ADDR, {5'h00, 1'b1, sel, 1'b0});
      sda_low_i = 1'b1;
      n = 0;
      while (wdt_expire_o !== 1'b1 && n < 100) begin
         step();
         n++;
      end
      sda_low_i = 1'b0;
      chk(24'(n), 24'(lim));
   endtask

   initial begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      close_out();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_n_i = 1'b0; feat_rdata_i = 8'h00; proc_overrun_i = 1'b0; proc_fatal_i = 1'b0;
      nvm_load_i = 1'b0; nvm_load_data_i = 20'h00000; nvm_busy_i = 1'b0;
      i2c_mode_i = 1'b1; sda_low_i = 1'b0; mismatches = 0; check_count = 0;
      al = '{accel_cfg_pkg::NVP_ADDR, accel_cfg_pkg::IFC_ADDR, accel_cfg_pkg::STC_ADDR,
             accel_cfg_pkg::NVC_ADDR, accel_cfg_pkg::XOFF_ADDR, accel_cfg_pkg::YOFF_ADDR,
             accel_cfg_pkg::ERR_ADDR};
      void'($urandom(32'h7537d668));
      do_reset();
      chk({nvm_prog_en_o, three_wire_select_o, aux_mag_o, selftest_en_o, selftest_pos_o,
           selftest_high_o, spi_en_o, offset_en_o, x_offset_o, y_offset_o}, 24'h0);
      chk(24'({proc_halt_o, nvm_prog_o, wdt_expire_o, feat_wr_o, feat_rd_o, reg_rdata_o,
               feat_wdata_o}), 24'h0);
      for (int i = 0; i < 7; i++) begin
         host_model_inst.rd(al[i], rv);
         chk(20'(rv), 20'(accel_cfg_pkg::REG_RESET));
      end
      host_model_inst.rd(8'h60, rv);
      chk(20'(rv), 20'h0);
      $display("test reset_values done");
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 7; i++) begin
            v = (k == 0) ? 8'($urandom) : ((k == 1) ? 8'hFF : 8'h00);
            if (i < 6) sh[i] = v & wmask(al[i]);
            host_model_inst.wr(al[i], v);
            host_model_inst.rd(al[i], rv);
            chk(20'(rv), 20'(v & wmask(al[i])));
         end
         chk(20'({nvm_prog_en_o, three_wire_select_o, aux_mag_o, selftest_en_o, selftest_pos_o,
                  selftest_high_o, spi_en_o, offset_en_o}),
             20'(cfg_view(sh[0], sh[1], sh[2], sh[3])));
         chk(20'({x_offset_o, y_offset_o}), 20'({sh[4], sh[5]}));
      end
      $display("test register_rw done");
      v = 8'($urandom);
      host_model_inst.wr(accel_cfg_pkg::FEAT_ADDR, v);
      chk({feat_wr_o, feat_wdata_o}, {1'b1, v});
      feat_rdata_i = 8'($urandom);
      host_model_inst.rd(accel_cfg_pkg::FEAT_ADDR, rv);
      chk({feat_rd_o, rv}, {1'b1, feat_rdata_i});
      $display("test feature_port done");
      host_model_inst.wr(accel_cfg_pkg::NVC_ADDR, 8'hF5);
      host_model_inst.wr(accel_cfg_pkg::XOFF_ADDR, 8'h3C);
      host_model_inst.wr(accel_cfg_pkg::YOFF_ADDR, 8'hA7);
      host_model_inst.wr(accel_cfg_pkg::NVP_ADDR, 8'h00);
      host_model_inst.wr(accel_cfg_pkg::CMD_ADDR, accel_cfg_pkg::CMD_NVM_PROG);
      chk(20'(nvm_prog_o), 20'h0);
      host_model_inst.wr(accel_cfg_pkg::NVP_ADDR, 8'h02);
      host_model_inst.wr(accel_cfg_pkg::CMD_ADDR, accel_cfg_pkg::CMD_NVM_PROG);
      chk({nvm_prog_o, nvm_image_o[18:0]}, {1'b1, 19'h273C5});
      chk(20'(nvm_image_o), 20'hA73C5);
      nvm_busy_i = 1'b1;
      host_model_inst.wr(accel_cfg_pkg::CMD_ADDR, accel_cfg_pkg::CMD_NVM_PROG);
      chk(24'(nvm_prog_o), 24'h0);
      nvm_busy_i = 1'b0;
      nvm_load_i = 1'b1;
      nvm_load_data_i = 20'($urandom);
      step();
      nvm_load_i = 1'b0;
      chk({y_offset_o, x_offset_o, offset_en_o, 2'b00, spi_en_o},
          {nvm_load_data_i[19:4], nvm_load_data_i[3], 2'b00, nvm_load_data_i[0]});
      $display("test nonvolatile done");
      wdt_run(1'b0, 8);
      wdt_run(1'b1, 20);
      for (int m = 0; m < 2; m++) begin
         host_model_inst.wr(accel_cfg_pkg::NVC_ADDR, (m == 0) ? 8'h00 : 8'h04);
         i2c_mode_i = (m == 0);
         sda_low_i = 1'b1;
         n = 0;
         repeat (40) begin
            step();
            if (wdt_expire_o !== 1'b0) n++;
         end
         sda_low_i = 1'b0;
         chk(24'(n), 24'h0);
      end
      i2c_mode_i = 1'b1;
      $display("test watchdog done");
      proc_overrun_i = 1'b1;
      step();
      proc_overrun_i = 1'b0;
      chk(20'(proc_halt_o), 20'h1);
      host_model_inst.rd(accel_cfg_pkg::ERR_ADDR, rv);
      chk(20'(rv), 20'h02);
      proc_fatal_i = 1'b1;
      step();
      proc_fatal_i = 1'b0;
      host_model_inst.wr(accel_cfg_pkg::ERR_ADDR, 8'h00);
      host_model_inst.rd(accel_cfg_pkg::ERR_ADDR, rv);
      chk({proc_halt_o, rv}, {1'b1, 8'h06});
      do_reset();
      host_model_inst.rd(accel_cfg_pkg::ERR_ADDR, rv);
      chk({proc_halt_o, rv}, {1'b0, 8'h00});
      $display("test error_flags done");
      close_out();
   end
endmodule
